// ===== rtl/adcwc_cfg.svh
// offsets, field positions, reset values and event bits of the converter control block
// assumes: included by the package and the design files by bare name
`ifndef ADCWC_CFG_SVH
`define ADCWC_CFG_SVH

// register byte offsets, one aligned word each
`define ADCWC_OFS_MODE0 8'h00
`define ADCWC_OFS_MODE2 8'h04
`define ADCWC_OFS_CHSEL 8'h08
`define ADCWC_OFS_UPPER 8'h0c
`define ADCWC_OFS_LOWER 8'h10
`define ADCWC_OFS_RESULT 8'h14
`define ADCWC_OFS_STAT 8'h18
`define ADCWC_OFS_MASK 8'h1c

// field positions
`define ADCWC_BIT_CE 0
`define ADCWC_BIT_TYP 0
`define ADCWC_BIT_RCK 3
`define ADCWC_BIT_NEGREF 5
`define ADCWC_BIT_PREF_LO 6
`define ADCWC_BIT_PREF_HI 7
`define ADCWC_BIT_ISS 7

// reset values
`define ADCWC_RST_MODE0 8'h00
`define ADCWC_RST_MODE2 8'h00
`define ADCWC_RST_CHSEL 8'h00
`define ADCWC_RST_UPPER 8'hff
`define ADCWC_RST_LOWER 8'h00
`define ADCWC_RST_MASK 3'h0

// channel code limits
`define ADCWC_CH_LAST_LOW 5'h0e
`define ADCWC_CH_FIRST_HIGH 5'h10
`define ADCWC_CH_LAST_HIGH 5'h14

// sticky event bits
`define ADCWC_EV_DONE 0
`define ADCWC_EV_SUPP 1
`define ADCWC_EV_BADCH 2
`define ADCWC_EV_NUM 3

`endif

// ===== rtl/adcwc_pkg.sv
// types and shared decode of the converter control block
// assumes: adcwc_cfg.svh on the include path
package adcwc_pkg;
  `include "adcwc_cfg.svh"

  typedef logic [7:0] adcwc_byte_t;

  typedef enum logic [1:0] {
    ADCWC_SRC_PIN = 2'b00,
    ADCWC_SRC_TEMP = 2'b01,
    ADCWC_SRC_IREF = 2'b10,
    ADCWC_SRC_BAD = 2'b11
  } adcwc_src_e;

  // classify a channel select byte; bits 6:5 must stay zero
  function automatic adcwc_src_e adcwc_classify(input adcwc_byte_t v);
    logic [4:0] code;
    code = v[4:0];
    if (v[6:5] != 2'h0) begin
      return ADCWC_SRC_BAD;
    end
    if (v[`ADCWC_BIT_ISS]) begin
      if (code == 5'h00) begin
        return ADCWC_SRC_TEMP;
      end
      if (code == 5'h01) begin
        return ADCWC_SRC_IREF;
      end
      return ADCWC_SRC_BAD;
    end
    if (code <= `ADCWC_CH_LAST_LOW) begin
      return ADCWC_SRC_PIN;
    end
    if (code >= `ADCWC_CH_FIRST_HIGH && code <= `ADCWC_CH_LAST_HIGH) begin
      return ADCWC_SRC_PIN;
    end
    return ADCWC_SRC_BAD;
  endfunction : adcwc_classify
endpackage : adcwc_pkg

// ===== rtl/adcwc_range_chk.sv
// result range check: one cycle from a valid result to its verdict
// assumes: limits and mode are stable software settings, sampled with the result
`timescale 1ns/1ps
module adcwc_range_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // result in
  input wire logic valid,
  input wire adcwc_pkg::adcwc_byte_t result8,
  input wire adcwc_pkg::adcwc_byte_t lower,
  input wire adcwc_pkg::adcwc_byte_t upper,
  input wire logic outside_mode,
  // verdict out
  output logic done,
  output logic pass
);
  import adcwc_pkg::*;

  logic done_ff;
  logic pass_ff;
  logic in_window;

  assign in_window = (lower <= result8) && (result8 <= upper);

  always_ff @(posedge clk) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= valid;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pass_ff <= 1'b0;
    end else if (valid) begin
      // limits inclusive on both edges in either mode
      if (outside_mode) begin
        pass_ff <= (result8 <= lower) || (upper <= result8);
      end else begin
        pass_ff <= in_window;
      end
    end
  end

  assign done = done_ff;
  assign pass = pass_ff;

  //////////////////////////////////////////////////////////////////////////////
  property p_inside;
    @(posedge clk) disable iff (rst)
    (valid && !outside_mode) |=> (done && pass == ($past(lower) <= $past(result8)
      && $past(result8) <= $past(upper)));
  endproperty
  a_inside: assert property (p_inside) else $error("inside check wrong");

  property p_outside;
    @(posedge clk) disable iff (rst)
    (valid && outside_mode) |=> (done && pass == ($past(result8) <= $past(lower)
      || $past(upper) <= $past(result8)));
  endproperty
  a_outside: assert property (p_outside) else $error("outside check wrong");
endmodule : adcwc_range_chk

// ===== rtl/adcwc_ctrl.sv
// digital control of a successive-approximation converter, AHB-Lite slave
// assumes: conv_done pulses one cycle with conv_data valid; single word transfers
// Summary of operation
// - mode 2 bit 5 picks the minus reference: 0 ground, 1 reference pin
// - range mode 0: interrupt only when lower <= result <= upper
// - range mode 1: interrupt only when result <= lower or result >= upper
// - mode 2 bit 0: 0 gives 10-bit results, 1 gives 8-bit results
// - internal source 0: 5-bit code picks pins 0-14 and 16-20
// - internal source 1: code 0 temperature, 1 reference; other codes refused
`timescale 1ns/1ps
`include "adcwc_cfg.svh"
module adcwc_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // converter core
  input wire logic conv_done,
  input wire logic [9:0] conv_data,
  output logic comparator_enable,
  output logic resolution_select,
  output logic neg_ref_select,
  output logic [1:0] pos_ref_select,
  output logic internal_source_select,
  output logic [4:0] channel_code,
  output logic temp_sensor_sel,
  output logic int_ref_sel,
  // interrupts
  output logic conversion_end_irq,
  output logic irq
);
  import adcwc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // bus capture
  logic addr_ok;
  logic wr_ph_ff;
  logic [7:0] wa_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;

  // registers
  adcwc_byte_t mode0_ff;
  adcwc_byte_t mode2_ff;
  adcwc_byte_t chsel_ff;
  adcwc_byte_t upper_ff;
  adcwc_byte_t lower_ff;
  logic [9:0] result_ff;
  logic [`ADCWC_EV_NUM-1:0] stat_ff;
  logic [`ADCWC_EV_NUM-1:0] mask_ff;
  logic [`ADCWC_EV_NUM-1:0] nxt_stat;
  logic [`ADCWC_EV_NUM-1:0] ev_set;
  logic tsel_ff;
  logic rsel_ff;
  logic irq_ff;
  logic endirq_ff;

  // conversion path
  logic conv_take;
  logic [9:0] conv_masked;
  logic chk_valid_ff;
  logic chk_done;
  logic chk_pass;
  logic stat_rd;
  logic wr_mode0;
  logic wr_mode2;
  logic wr_chsel;
  adcwc_src_e wr_src;

  // full word single transfers only; hsize is not checked beyond that
  assign addr_ok = hsel && hready && htrans[1];

  //////////////////////////////////////////////////////////////////////////////
  // register read mux, evaluated in the address phase
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    case (a)
      `ADCWC_OFS_MODE0: rd_word = {24'h0, mode0_ff};
      `ADCWC_OFS_MODE2: rd_word = {24'h0, mode2_ff};
      `ADCWC_OFS_CHSEL: rd_word = {24'h0, chsel_ff};
      `ADCWC_OFS_UPPER: rd_word = {24'h0, upper_ff};
      `ADCWC_OFS_LOWER: rd_word = {24'h0, lower_ff};
      `ADCWC_OFS_RESULT: rd_word = {22'h0, result_ff};
      `ADCWC_OFS_STAT: rd_word = {29'h0, stat_ff};
      `ADCWC_OFS_MASK: rd_word = {29'h0, mask_ff};
      default: rd_word = 32'h0;
    endcase
  endfunction : rd_word

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ph_ff <= 1'b0;
      wa_ff <= 8'h00;
    end else begin
      wr_ph_ff <= addr_ok && hwrite;
      wa_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata_ff <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      hrdata_ff <= rd_word(haddr[7:0]);
    end
  end

  // zero wait states, always OKAY; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout_ff <= 1'b0;
      hresp_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register writes in the data phase
  assign wr_mode0 = wr_ph_ff && (wa_ff == `ADCWC_OFS_MODE0);
  assign wr_mode2 = wr_ph_ff && (wa_ff == `ADCWC_OFS_MODE2);
  assign wr_chsel = wr_ph_ff && (wa_ff == `ADCWC_OFS_CHSEL);
  assign wr_src = adcwc_classify(hwdata[7:0]);

  always_ff @(posedge clk) begin
    if (rst) begin
      mode0_ff <= `ADCWC_RST_MODE0;
    end else if (wr_mode0) begin
      mode0_ff <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode2_ff <= `ADCWC_RST_MODE2;
    end else if (wr_mode2) begin
      // bit 5 minus reference, bit 3 range mode, bit 0 resolution
      mode2_ff <= hwdata[7:0];
    end
  end

  // a prohibited code is refused so the multiplexer never sees it
  always_ff @(posedge clk) begin
    if (rst) begin
      chsel_ff <= `ADCWC_RST_CHSEL;
      tsel_ff <= 1'b0;
      rsel_ff <= 1'b0;
    end else if (wr_chsel && wr_src != ADCWC_SRC_BAD) begin
      chsel_ff <= hwdata[7:0];
      tsel_ff <= (wr_src == ADCWC_SRC_TEMP);
      rsel_ff <= (wr_src == ADCWC_SRC_IREF);
    end
  end

  // limits have no effect on reset beyond the open window
  always_ff @(posedge clk) begin
    if (rst) begin
      upper_ff <= `ADCWC_RST_UPPER;
      lower_ff <= `ADCWC_RST_LOWER;
    end else if (wr_ph_ff) begin
      if (wa_ff == `ADCWC_OFS_UPPER) begin
        upper_ff <= hwdata[7:0];
      end
      if (wa_ff == `ADCWC_OFS_LOWER) begin
        lower_ff <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_ff <= `ADCWC_RST_MASK;
    end else if (wr_ph_ff && wa_ff == `ADCWC_OFS_MASK) begin
      mask_ff <= hwdata[`ADCWC_EV_NUM-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // conversion capture; a stopped comparator produces nothing to check
  assign conv_take = conv_done && mode0_ff[`ADCWC_BIT_CE];
  // 8-bit results sit in the top bits, low two bits forced to zero
  assign conv_masked = mode2_ff[`ADCWC_BIT_TYP] ? {conv_data[9:2], 2'b00} : conv_data;

  always_ff @(posedge clk) begin
    if (rst) begin
      result_ff <= 10'h000;
      chk_valid_ff <= 1'b0;
    end else begin
      chk_valid_ff <= conv_take;
      if (conv_take) begin
        result_ff <= conv_masked;
      end
    end
  end

  // the limits are 8 bits wide, so the top eight result bits are compared
  adcwc_range_chk u_chk (
    .clk(clk),
    .rst(rst),
    .valid(chk_valid_ff),
    .result8(result_ff[9:2]),
    .lower(lower_ff),
    .upper(upper_ff),
    .outside_mode(mode2_ff[`ADCWC_BIT_RCK]),
    .done(chk_done),
    .pass(chk_pass)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      endirq_ff <= 1'b0;
    end else begin
      endirq_ff <= chk_done && chk_pass;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky events; a read of the status word clears it, a new event wins
  assign stat_rd = addr_ok && !hwrite && (haddr[7:0] == `ADCWC_OFS_STAT);

  always_comb begin
    ev_set = '0;
    ev_set[`ADCWC_EV_DONE] = chk_done && chk_pass;
    ev_set[`ADCWC_EV_SUPP] = chk_done && !chk_pass;
    ev_set[`ADCWC_EV_BADCH] = wr_chsel && (wr_src == ADCWC_SRC_BAD);
    nxt_stat = (stat_rd ? '0 : stat_ff) | ev_set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_stat & mask_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign comparator_enable = mode0_ff[`ADCWC_BIT_CE];
  assign resolution_select = mode2_ff[`ADCWC_BIT_TYP];
  assign neg_ref_select = mode2_ff[`ADCWC_BIT_NEGREF];
  assign pos_ref_select = {mode2_ff[`ADCWC_BIT_PREF_HI], mode2_ff[`ADCWC_BIT_PREF_LO]};
  assign internal_source_select = chsel_ff[`ADCWC_BIT_ISS];
  assign channel_code = chsel_ff[4:0];
  assign temp_sensor_sel = tsel_ff;
  assign int_ref_sel = rsel_ff;
  assign conversion_end_irq = endirq_ff;
  assign irq = irq_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_negref;
    wr_mode2 |=> neg_ref_select == $past(hwdata[`ADCWC_BIT_NEGREF]);
  endproperty
  a_negref: assert property (p_negref) else $error("minus reference not taken");

  property p_pass_irq;
    (chk_done && chk_pass && !mode2_ff[`ADCWC_BIT_RCK]) |=> conversion_end_irq;
  endproperty
  a_pass_irq: assert property (p_pass_irq) else $error("inside pass lost irq");

  property p_conv_to_irq;
    (conv_take && mode2_ff[`ADCWC_BIT_RCK]) ##2 chk_pass |=> conversion_end_irq;
  endproperty
  a_conv_to_irq: assert property (p_conv_to_irq) else $error("outside pass lost irq");

  property p_res8;
    (conv_take && mode2_ff[`ADCWC_BIT_TYP]) |=> result_ff[1:0] == 2'b00
      && result_ff[9:2] == $past(conv_data[9:2]);
  endproperty
  a_res8: assert property (p_res8) else $error("8-bit result wrong");

  property p_pin_code;
    (wr_chsel && wr_src == ADCWC_SRC_PIN) |=> channel_code == $past(hwdata[4:0])
      && !internal_source_select && !temp_sensor_sel && !int_ref_sel;
  endproperty
  a_pin_code: assert property (p_pin_code) else $error("pin code not taken");

  property p_bad_code;
    (wr_chsel && wr_src == ADCWC_SRC_BAD) |=> $stable(chsel_ff)
      && stat_ff[`ADCWC_EV_BADCH];
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code accepted");

  property p_ce_off;
    (conv_done && !comparator_enable) |=> $stable(result_ff) ##1 !chk_done;
  endproperty
  a_ce_off: assert property (p_ce_off) else $error("stopped comparator converted");

  property p_supp;
    (chk_done && !chk_pass) |=> !conversion_end_irq && stat_ff[`ADCWC_EV_SUPP];
  endproperty
  a_supp: assert property (p_supp) else $error("failed check raised irq");

  property p_irq_lvl;
    irq == |($past(nxt_stat) & $past(mask_ff));
  endproperty
  a_irq_lvl: assert property (p_irq_lvl) else $error("irq level wrong");

  property p_internal_code;
    (wr_chsel && (wr_src == ADCWC_SRC_TEMP || wr_src == ADCWC_SRC_IREF)) |=>
      internal_source_select && temp_sensor_sel == !$past(hwdata[0])
      && int_ref_sel == $past(hwdata[0]);
  endproperty
  a_internal_code: assert property (p_internal_code) else $error("internal source not taken");

  // the ready flop comes up one edge after release, so that edge is skipped
  property p_okay;
    !$past(rst) |-> hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready and okay");

  c_pass: cover property (conv_take ##2 conversion_end_irq);
  c_supp: cover property (chk_done && !chk_pass);
  c_bad: cover property (wr_chsel && wr_src == ADCWC_SRC_BAD);
  c_clear: cover property (stat_rd && stat_ff != '0);
endmodule : adcwc_ctrl

// ===== test/adc_control_window_compare_test.sv
// self-checking bench for the converter control block
// assumes: adcwc_ctrl with adcwc_pkg and adcwc_cfg.svh compiled beside it
`timescale 1ns/1ps
`include "adcwc_cfg.svh"
module adc_control_window_compare_test;
  import adcwc_pkg::*;
  localparam logic [7:0] a_m0 = `ADCWC_OFS_MODE0;
  localparam logic [7:0] a_m2 = `ADCWC_OFS_MODE2;
  localparam logic [7:0] a_ch = `ADCWC_OFS_CHSEL;
  localparam logic [7:0] a_up = `ADCWC_OFS_UPPER;
  localparam logic [7:0] a_lo = `ADCWC_OFS_LOWER;
  localparam logic [7:0] a_res = `ADCWC_OFS_RESULT;
  localparam logic [7:0] a_st = `ADCWC_OFS_STAT;
  localparam logic [7:0] a_mk = `ADCWC_OFS_MASK;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic conv_done = 1'b0;
  logic [9:0] conv_data = 10'h0;
  wire logic hready;
  wire logic [31:0] hrdata;
  wire logic hresp;
  wire logic comparator_enable, resolution_select, neg_ref_select;
  wire logic internal_source_select, temp_sensor_sel, int_ref_sel;
  wire logic [1:0] pos_ref_select;
  wire logic [4:0] channel_code;
  wire logic conversion_end_irq, irq;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [7:0] vals [6] = '{8'h3f, 8'h40, 8'h41, 8'h7f, 8'h80, 8'h81};

  always #2.5 clk = ~clk;

  adcwc_ctrl dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .conv_done(conv_done), .conv_data(conv_data),
    .comparator_enable(comparator_enable), .resolution_select(resolution_select),
    .neg_ref_select(neg_ref_select), .pos_ref_select(pos_ref_select),
    .internal_source_select(internal_source_select), .channel_code(channel_code),
    .temp_sensor_sel(temp_sensor_sel), .int_ref_sel(int_ref_sel),
    .conversion_end_irq(conversion_end_irq), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one single transfer; the slave is its own hready, so waits end on it
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
    @(negedge clk);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk($sformatf("reg %h", a), e, r);
  endtask : rdc

  // one result pulse; the pulse must show exactly once, or not at all
  task conv(input logic [9:0] d, input logic e);
    int n;
    n = 0;
    @(posedge clk);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge clk);
    conv_done <= 1'b0;
    conv_data <= ~d;
    repeat (5) begin
      @(posedge clk);
      if (conversion_end_irq === 1'b1) n++;
    end
    chk("irq pulses", 32'(e), 32'(n));
  endtask : conv

  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rdc(a_m0, 32'h0);
    rdc(a_m2, 32'h0);
    rdc(a_ch, 32'h0);
    rdc(a_up, 32'hff);
    rdc(a_lo, 32'h0);
    rdc(a_mk, 32'h0);
    rdc(a_st, 32'h0);
    wr(8'h20, 32'h55);
    rdc(8'h20, 32'h0);
  endtask : t_reset

  task t_mode;
    wr(a_m0, 32'h1);
    chk("comparator_enable", 32'h1, 32'(comparator_enable));
    wr(a_m2, 32'h20);
    chk("neg_ref_select", 32'h1, 32'(neg_ref_select));
    chk("resolution_select", 32'h0, 32'(resolution_select));
    wr(a_m2, 32'h01);
    chk("neg_ref_select", 32'h0, 32'(neg_ref_select));
    chk("resolution_select", 32'h1, 32'(resolution_select));
    wr(a_m0, 32'h0);
    chk("comparator_enable", 32'h0, 32'(comparator_enable));
  endtask : t_mode

  task t_chan;
    logic [7:0] v;
    logic [7:0] acc;
    logic bad;
    acc = 8'h00;
    for (int i = 0; i < 35; i++) begin
      v = (i < 32) ? 8'(i) : 8'h80 + 8'(i - 32);
      bad = (i < 32) ? (i == 15 || i > 20) : (i == 34);
      if (!bad) acc = v;
      wr(a_ch, {24'h0, v});
      chk("channel_code", 32'(acc[4:0]), 32'(channel_code));
      chk("internal_source_select", 32'(acc[7]), 32'(internal_source_select));
      chk("temp_sensor_sel", 32'(acc == 8'h80), 32'(temp_sensor_sel));
      chk("int_ref_sel", 32'(acc == 8'h81), 32'(int_ref_sel));
      rdc(a_st, bad ? 32'h4 : 32'h0);
    end
    wr(a_ch, 32'h0);
  endtask : t_chan

  // limits 0x40..0x80 against both check modes and both resolutions
  task t_range;
    logic [7:0] b;
    logic ok;
    wr(a_m0, 32'h1);
    wr(a_lo, 32'h40);
    wr(a_up, 32'h80);
    for (int m = 0; m < 4; m++) begin
      wr(a_m2, {28'h0, m[1], 2'b00, m[0]});
      for (int j = 0; j < 6; j++) begin
        b = vals[j];
        ok = m[1] ? (b <= 8'h40 || b >= 8'h80) : (b >= 8'h40 && b <= 8'h80);
        conv({b, 2'b01}, ok);
        rdc(a_res, m[0] ? {22'h0, b, 2'b00} : {22'h0, b, 2'b01});
        rdc(a_st, ok ? 32'h1 : 32'h2);
      end
    end
  endtask : t_range

  task t_irq;
    wr(a_lo, 32'h0);
    wr(a_up, 32'hff);
    wr(a_m2, 32'h0);
    wr(a_mk, 32'h1);
    conv(10'h000, 1'b1);
    @(negedge clk);
    chk("irq", 32'h1, 32'(irq));
    rdc(a_st, 32'h1);
    @(negedge clk);
    chk("irq", 32'h0, 32'(irq));
    wr(a_mk, 32'h0);
    conv(10'h3ff, 1'b1);
    chk("irq", 32'h0, 32'(irq));
    rdc(a_st, 32'h1);
    wr(a_mk, 32'h4);
    wr(a_ch, 32'h0f);
    chk("irq", 32'h1, 32'(irq));
    rdc(a_st, 32'h4);
    @(negedge clk);
    chk("irq", 32'h0, 32'(irq));
    rdc(a_mk, 32'h4);
    // a stopped comparator drops results without a trace
    wr(a_m0, 32'h0);
    conv(10'h100, 1'b0);
    rdc(a_st, 32'h0);
  endtask : t_irq

  // plus reference change in the safe order: stop, rewrite, settle, restart, settle
  task t_pref;
    wr(a_m0, 32'h0);
    wr(a_m2, 32'h80);
    chk("pos_ref_select", 32'h2, 32'(pos_ref_select));
    repeat (8) @(posedge clk);
    wr(a_m0, 32'h1);
    repeat (8) @(posedge clk);
    conv(10'h200, 1'b1);
    rdc(a_st, 32'h1);
    rdc(a_m2, 32'h80);
  endtask : t_pref

  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mode();
    t_chan();
    t_range();
    t_irq();
    t_pref();
    end_sim();
  end

  // the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule : adc_control_window_compare_test
